// >>> shared/core_regs_pkg.sv
// constants, field layouts and carrier types for the core flags/config register bank
package core_regs_pkg;

	// ****************************************
	// file addresses and bank layout
	// ****************************************
	localparam logic [6:0] FILE_INDIRECT   = 7'h00;
	localparam logic [6:0] FILE_PC_LOW     = 7'h02;
	localparam logic [6:0] FILE_FLAGS      = 7'h03;
	localparam logic [6:0] FILE_POINTER    = 7'h04;
	localparam logic [6:0] FILE_PC_HIGH    = 7'h0a;
	localparam logic [7:0] ADDR_CONFIG     = 8'h81;
	localparam logic [7:0] GPR0_LO         = 8'h20;
	localparam logic [7:0] GPR0_HI         = 8'h7f;
	localparam logic [7:0] GPR1_LO         = 8'ha0;
	localparam logic [7:0] GPR1_HI         = 8'hbf;
	localparam logic [7:0] GPR1_INDEX_BASE = 8'h40;
	localparam logic [7:0] COMMON_LO       = 8'hf0;
	localparam logic [7:0] COMMON_OFS      = 8'h80;
	localparam int         GPR_DEPTH       = 128;

	// ****************************************
	// field positions
	// ****************************************
	localparam int FLG_CARRY   = 0;
	localparam int FLG_HALF    = 1;
	localparam int FLG_ZERO    = 2;
	localparam int FLG_PWRDN   = 3;
	localparam int FLG_TIMEOUT = 4;
	localparam int FLG_BANK    = 5;
	localparam int CFG_PSA     = 3;
	localparam int CFG_EDGE    = 4;
	localparam int CFG_SOURCE  = 5;
	localparam int CFG_INTEDGE = 6;
	localparam int CFG_PULLUP  = 7;

	// ****************************************
	// reset values and masks
	// ****************************************
	localparam logic [7:0]  FLAGS_POR    = 8'h18;
	localparam logic [7:0]  CONFIG_RST   = 8'hff;
	localparam logic [7:0]  POINTER_POR  = 8'h00;
	localparam logic [7:0]  PC_HIGH_RST  = 8'h00;
	localparam logic [7:0]  PC_HIGH_MASK = 8'h1f;
	localparam logic [12:0] PC_RST       = 13'h0000;

	// other special registers: plain storage, address / implemented bits / reset / kept on warm reset / mirrored
	localparam int         PERI_N     = 11;
	localparam int         PERI_PORT_B_PINS = 2;
	localparam logic [7:0] PERI_ADDR   [PERI_N] = '{8'h01, 8'h05, 8'h06, 8'h0b, 8'h0c, 8'h1f,
		8'h85, 8'h86, 8'h8c, 8'h8e, 8'h9f};
	localparam logic [7:0] PERI_MASK   [PERI_N] = '{8'hff, 8'h1f, 8'hff, 8'hff, 8'h40, 8'hcf,
		8'h1f, 8'hff, 8'h40, 8'h03, 8'hef};
	localparam logic [7:0] PERI_RST    [PERI_N] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h1f, 8'hff, 8'h00, 8'h00, 8'h00};
	localparam bit         PERI_KEEP   [PERI_N] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
		1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	localparam bit         PERI_MIRROR [PERI_N] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
		1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {ALU_NONE, ALU_LOGIC, ALU_ADD, ALU_SUB, ALU_ROT_LEFT, ALU_ROT_RIGHT} aluOp_t;
	typedef enum logic [1:0] {RST_MASTER_CLEAR_PIN, RST_BROWNOUT, RST_WATCHDOG} rstCause_t;

	typedef struct packed {
		aluOp_t     op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] result;
	} aluReq_t;

	typedef struct packed {
		logic       pullupDisable;
		logic       extIrqRising;
		logic       timerExtClock;
		logic       timerFallEdge;
		logic       prescalerToWdt;
		logic [3:0] timerDivLog2;
		logic [2:0] wdtDivLog2;
	} cfgView_t;

endpackage

// >>> logic/core_status_option_regs.sv
// core flags, configuration, pointer, program counter and data-memory map of the cpu register file
`timescale 1ns/1ps

// Operation
// - bank bit 0 selects bank 0, 1 bank 1
// - unimplemented locations read as zero
// - flag-updating ops override writes to low flags
// - timeout and power-down flags ignore writes
// - timeout flag set on power-up/clear/sleep, cleared on timeout
// - power-down flag set on power-up/clear, cleared by sleep
// - zero flag follows result equal zero
// - half-carry is nibble carry, borrow inverted
// - carry is msb carry, set means no borrow
// - rotates load carry from shifted-out bit
// - config bit 7 disables port pull-ups
// - config bit 6 picks interrupt edge
// - config bit 5 picks timer clock source
// - config bit 4 picks external clock edge
// - config bit 3 assigns prescaler to watchdog
// - rate code sets timer and watchdog divisions
// - power-on and warm reset load different values
// - common ram at F0-FF mirrors 70-7F
// - indirect location uses pointer, self reads zero
// - low pc write loads upper bits from latch
// - every reset clears program counter
module core_status_option_regs
	import core_regs_pkg::*;
#(
	parameter int PC_WIDTH   = 13,
	parameter bit COMMON_RAM = 1'b1,
	parameter bit BANK1_GPR  = 1'b1
) (
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  resetPowerOn,
	input  wire rstCause_t             resetCause,
	input  wire logic                  rdEn,
	input  wire logic [6:0]            rdFile,
	output logic      [7:0]            rdData,
	input  wire logic                  wrEn,
	input  wire logic [6:0]            wrFile,
	input  wire logic [7:0]            wrData,
	input  wire aluReq_t               alu,
	input  wire logic                  watchdogClearInstr,
	input  wire logic                  sleepInstr,
	input  wire logic                  watchdogTimeout,
	input  wire logic                  pcStep,
	output logic [PC_WIDTH-1:0]        pcValue,
	output logic      [7:0]            flags,
	output cfgView_t                   cfgView,
	output logic      [7:0]            pullupEnable,
	output logic      [PERI_N*8-1:0]   periImage
);

	// ****************************************
	// parameter checks
	// ****************************************
	if (PC_WIDTH < 9 || PC_WIDTH > 13) begin : g_bad_pc
		$error("PC_WIDTH must lie between 9 and 13");
	end

	// ****************************************
	// state
	// ****************************************
	logic [7:0]          flagsQ;
	logic [7:0]          flagsD;
	logic [7:0]          cfgQ;
	logic [7:0]          pointerQ;
	logic [7:0]          pcHighQ;
	logic [PC_WIDTH-1:0] pcQ;
	logic [7:0]          rdDataQ;
	logic [7:0]          gpr [0:GPR_DEPTH-1];
	logic [7:0]          periQ [PERI_N];
	logic [PERI_N-1:0]   periRdHit;
	logic [PERI_N-1:0]   periWrHit;

	// ****************************************
	// address formation
	// ****************************************
	logic [7:0] rdAddr;
	logic [7:0] wrAddr;
	logic       rdSelf;
	logic       wrSelf;
	logic       wrLive;

	assign rdAddr = (rdFile == FILE_INDIRECT) ? pointerQ : {flagsQ[FLG_BANK], rdFile};
	assign wrAddr = (wrFile == FILE_INDIRECT) ? pointerQ : {flagsQ[FLG_BANK], wrFile};
	// a pointer aimed back at the indirect location reads zero and swallows writes
	assign rdSelf = (rdFile == FILE_INDIRECT) && (pointerQ[6:0] == FILE_INDIRECT);
	assign wrSelf = (wrFile == FILE_INDIRECT) && (pointerQ[6:0] == FILE_INDIRECT);
	assign wrLive = wrEn && !wrSelf;
	function automatic logic [7:0] foldCommon(input logic [7:0] addr);
		foldCommon = (COMMON_RAM && addr >= COMMON_LO) ? addr - COMMON_OFS : addr;
	endfunction
	function automatic logic gprHit(input logic [7:0] addr);
		logic [7:0] a;
		a = foldCommon(addr);
		gprHit = (a >= GPR0_LO && a <= GPR0_HI) || (BANK1_GPR && a >= GPR1_LO && a <= GPR1_HI);
	endfunction
	function automatic logic [6:0] gprIndex(input logic [7:0] addr);
		logic [7:0] a;
		a = foldCommon(addr);
		gprIndex = (a <= GPR0_HI) ? 7'(a - GPR0_LO) : 7'(a - GPR1_INDEX_BASE);
	endfunction
	logic wrFlags;
	logic wrPointer;
	logic wrPcLow;
	logic wrPcHigh;
	logic wrConfig;
	assign wrFlags   = wrLive && (wrAddr[6:0] == FILE_FLAGS);
	assign wrPointer = wrLive && (wrAddr[6:0] == FILE_POINTER);
	assign wrPcLow   = wrLive && (wrAddr[6:0] == FILE_PC_LOW);
	assign wrPcHigh  = wrLive && (wrAddr[6:0] == FILE_PC_HIGH);
	assign wrConfig  = wrLive && (wrAddr == ADDR_CONFIG);

	// ****************************************
	// arithmetic flags
	// ****************************************
	logic [8:0] sum;
	logic [4:0] nib;
	logic [2:0] aluAff;
	logic [2:0] aluVal;
	always_comb begin
		sum    = 9'h000;
		nib    = 5'h00;
		aluAff = 3'b000;
		aluVal = 3'b000;
		case (alu.op)
			ALU_LOGIC: begin
				aluAff[FLG_ZERO] = 1'b1;
				aluVal[FLG_ZERO] = (alu.result == 8'h00);
			end
			ALU_ADD, ALU_SUB: begin
				// subtraction adds the two's complement, so a set carry means no borrow
				if (alu.op == ALU_ADD) begin
					sum = {1'b0, alu.a} + {1'b0, alu.b};
					nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
				end else begin
					sum = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
					nib = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
				end
				aluAff = 3'b111;
				aluVal[FLG_CARRY] = sum[8];
				aluVal[FLG_HALF]  = nib[4];
				aluVal[FLG_ZERO]  = (sum[7:0] == 8'h00);
			end
			ALU_ROT_LEFT, ALU_ROT_RIGHT: begin
				aluAff[FLG_CARRY] = 1'b1;
				aluVal[FLG_CARRY] = (alu.op == ALU_ROT_LEFT) ? alu.a[7] : alu.a[0];
			end
			default: aluAff = 3'b000;
		endcase
	end

	// ****************************************
	// flags register
	// ****************************************
	always_comb begin
		flagsD = flagsQ;
		if (wrFlags) begin
			flagsD[7:5] = wrData[7:5];
			if (aluAff == 3'b000) begin
				flagsD[2:0] = wrData[2:0];
			end
		end
		// hardware result wins over the write for every flag the instruction touches
		for (int k = 0; k < 3; k++) begin
			if (aluAff[k]) begin
				flagsD[k] = aluVal[k];
			end
		end
		// timeout/power-down bits never take write data, only these events
		if (watchdogClearInstr) begin
			flagsD[FLG_TIMEOUT] = 1'b1;
			flagsD[FLG_PWRDN]   = 1'b1;
		end
		if (sleepInstr) begin
			flagsD[FLG_TIMEOUT] = 1'b1;
			flagsD[FLG_PWRDN]   = 1'b0;
		end
		if (watchdogTimeout) begin
			flagsD[FLG_TIMEOUT] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			if (resetPowerOn) begin
				flagsQ <= FLAGS_POR;
			end else begin
				flagsQ <= {3'b000, (resetCause != RST_WATCHDOG) && flagsQ[FLG_TIMEOUT], flagsQ[3:0]};
			end
		end else begin
			flagsQ <= flagsD;
		end
	end

	// ****************************************
	// configuration, pointer, program counter
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfgQ <= CONFIG_RST;
		end else if (wrConfig) begin
			cfgQ <= wrData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst && resetPowerOn) begin
			pointerQ <= POINTER_POR;
		end else if (!sys_rst && wrPointer) begin
			pointerQ <= wrData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pcHighQ <= PC_HIGH_RST;
		end else if (wrPcHigh) begin
			pcHighQ <= wrData & PC_HIGH_MASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pcQ <= PC_RST[PC_WIDTH-1:0];
		end else if (wrPcLow) begin
			pcQ <= {pcHighQ[PC_WIDTH-9:0], wrData};
		end else if (pcStep) begin
			pcQ <= pcQ + 1'b1;
		end
	end

	// ****************************************
	// general-purpose ram and other special registers
	// ****************************************
	// no reset on the ram: contents are undefined after power-up anyway
	always_ff @(posedge sys_clk) begin
		if (!sys_rst && wrLive && gprHit(wrAddr)) begin
			gpr[gprIndex(wrAddr)] <= wrData;
		end
	end

	for (genvar i = 0; i < PERI_N; i++) begin : g_peri
		assign periRdHit[i] = PERI_MIRROR[i] ? (rdAddr[6:0] == PERI_ADDR[i][6:0]) : (rdAddr == PERI_ADDR[i]);
		assign periWrHit[i] = PERI_MIRROR[i] ? (wrAddr[6:0] == PERI_ADDR[i][6:0]) : (wrAddr == PERI_ADDR[i]);
		assign periImage[i*8 +: 8] = periQ[i];
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				if (resetPowerOn || !PERI_KEEP[i]) begin
					periQ[i] <= PERI_RST[i];
				end
			end else if (wrLive && periWrHit[i]) begin
				periQ[i] <= wrData & PERI_MASK[i];
			end
		end
	end

	// ****************************************
	// read path
	// ****************************************
	logic [7:0] rdValue;
	always_comb begin
		rdValue = 8'h00;
		if (!rdSelf) begin
			if (rdAddr[6:0] == FILE_PC_LOW) begin
				rdValue = pcQ[7:0];
			end else if (rdAddr[6:0] == FILE_FLAGS) begin
				rdValue = flagsQ;
			end else if (rdAddr[6:0] == FILE_POINTER) begin
				rdValue = pointerQ;
			end else if (rdAddr[6:0] == FILE_PC_HIGH) begin
				rdValue = pcHighQ;
			end else if (rdAddr == ADDR_CONFIG) begin
				rdValue = cfgQ;
			end else if (gprHit(rdAddr)) begin
				rdValue = gpr[gprIndex(rdAddr)];
			end else begin
				for (int k = 0; k < PERI_N; k++) begin
					if (periRdHit[k]) begin
						rdValue = periQ[k];
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdDataQ <= 8'h00;
		end else if (rdEn) begin
			rdDataQ <= rdValue;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rdData  = rdDataQ;
	assign flags   = flagsQ;
	assign pcValue = pcQ;

	assign cfgView.pullupDisable  = cfgQ[CFG_PULLUP];
	assign cfgView.extIrqRising   = cfgQ[CFG_INTEDGE];
	assign cfgView.timerExtClock  = cfgQ[CFG_SOURCE];
	assign cfgView.timerFallEdge  = cfgQ[CFG_EDGE];
	assign cfgView.prescalerToWdt = cfgQ[CFG_PSA];
	assign cfgView.timerDivLog2   = {1'b0, cfgQ[2:0]} + 4'h1;
	assign cfgView.wdtDivLog2     = cfgQ[2:0];
	assign pullupEnable = cfgQ[CFG_PULLUP] ? 8'h00 : periQ[PERI_PORT_B_PINS];

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence sSleep;
		sleepInstr && !watchdogTimeout && !watchdogClearInstr;
	endsequence
	sequence sQuiet;
		!sleepInstr && !watchdogTimeout && !watchdogClearInstr;
	endsequence
	a_status_wr_guard: assert property (
		(wrFlags and sQuiet) |=> flags[4:3] == $past(flagsQ[4:3]))
		else $error("timeout/power-down bits changed by a write");
	a_sleep_flags: assert property (
		sSleep ##1 sQuiet[*2] |-> flags[FLG_TIMEOUT] && !flags[FLG_PWRDN])
		else $error("sleep did not set timeout and clear power-down");
	a_clear_flags: assert property (
		watchdogClearInstr && !sleepInstr && !watchdogTimeout |=> flags[4:3] == 2'b11)
		else $error("watchdog clear did not set both flags");
	a_zero_flag: assert property (
		alu.op == ALU_LOGIC |=> flags[FLG_ZERO] == ($past(alu.result) == 8'h00))
		else $error("zero flag does not match result");
	a_sub_borrow: assert property (
		alu.op == ALU_SUB |=> flags[1:0] == {$past(alu.a[3:0]) >= $past(alu.b[3:0]), $past(alu.a) >= $past(alu.b)})
		else $error("subtract carry/half-carry wrong");
	a_add_carry: assert property (
		alu.op == ALU_ADD |=> flags[FLG_CARRY] == (({1'b0, $past(alu.a)} + {1'b0, $past(alu.b)}) > 9'h0ff))
		else $error("add carry wrong");
	a_rotate_carry: assert property (
		alu.op == ALU_ROT_RIGHT |=> flags[FLG_CARRY] == $past(alu.a[0]))
		else $error("rotate carry wrong");
	a_write_suppress: assert property (
		wrFlags && alu.op == ALU_ADD |=> flags[FLG_ZERO] == ($past(alu.a) + $past(alu.b) == 8'h00))
		else $error("flag write not suppressed");
	a_pc_load: assert property (
		wrPcLow |=> pcValue == {$past(pcHighQ[PC_WIDTH-9:0]), $past(wrData)})
		else $error("pc low write did not load upper bits");
	a_pc_reset: assert property (
		$fell(sys_rst) |-> pcValue == '0)
		else $error("pc not cleared by reset");
	a_unimpl_zero: assert property (
		rdEn && rdFile == 7'h07 |=> rdData == 8'h00)
		else $error("unimplemented location read nonzero");
	a_self_zero: assert property (
		rdEn && rdSelf |=> rdData == 8'h00)
		else $error("indirect self read nonzero");
	a_prescale_rate: assert property (
		wrConfig |=> cfgView.wdtDivLog2 == $past(wrData[2:0]) && cfgView.timerDivLog2 == 4'($past(wrData[2:0])) + 4'h1)
		else $error("timer and watchdog rates do not follow the rate code");

endmodule

// >>> test/cpu_core_model.sv
// cpu core datapath model that issues operand reads, destination writes, alu results and events
`timescale 1ns/1ps

// ****************************************
// core datapath model
// ****************************************
module cpu_core_model
	import core_regs_pkg::*;
(
	input  wire logic  sys_clk,
	output logic       rdEn,
	output logic [6:0] rdFile,
	output logic       wrEn,
	output logic [6:0] wrFile,
	output logic [7:0] wrData,
	output aluReq_t    alu,
	output logic [2:0] ev,
	output logic       pcStep
);
	initial begin
		{rdEn, wrEn, pcStep, ev} = '0;
		{rdFile, wrFile, wrData} = '0;
		alu = '0;
	end

	// one instruction step; released lines show the inverse so a stale value never passes for a live one
	task automatic issue(input logic r, input logic [6:0] rf, input logic w, input logic [6:0] wf,
		input logic [7:0] wd, input aluOp_t op, input logic [7:0] a, input logic [7:0] b, input logic [3:0] evs);
		@(posedge sys_clk);
		#1;
		rdEn = r;
		rdFile = r ? rf : ~rdFile;
		wrEn = w;
		wrFile = w ? wf : ~wrFile;
		wrData = !w ? ~wrData : (wf == FILE_FLAGS) ? {2'b00, wd[5:0]} : wd;
		alu.op = op;
		alu.a = a;
		alu.b = b;
		alu.result = (op == ALU_SUB) ? a - b : (op == ALU_ADD) ? a + b : a & b;
		{pcStep, ev} = evs;
	endtask
endmodule

// >>> test/core_status_option_regs_tb.sv
// self-checking bench for the core flags and configuration register bank
`timescale 1ns/1ps

module core_status_option_regs_tb
	import core_regs_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        sys_rst;
	logic        resetPowerOn;
	rstCause_t   resetCause;
	logic        rdEn;
	logic [6:0]  rdFile;
	logic [7:0]  rdData;
	logic        wrEn;
	logic [6:0]  wrFile;
	logic [7:0]  wrData;
	aluReq_t     alu;
	logic [2:0]  ev;
	logic        pcStep;
	logic [12:0] pcValue;
	logic [7:0]  flags;
	cfgView_t    cfgView;
	logic [7:0]  pullupEnable;
	logic        rdPend = 1'b0;
	logic [7:0]  expQ[$];
	logic [7:0]  fl;
	logic [7:0]  v;
	logic [7:0]  a;
	logic [7:0]  b;
	aluOp_t      op;
	int          errors = 0;
	int          nChecks = 0;
	int          seed = 48492;

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	core_status_option_regs i_core_status_option_regs (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.resetPowerOn(resetPowerOn), .resetCause(resetCause), .rdEn(rdEn), .rdFile(rdFile), .rdData(rdData),
		.wrEn(wrEn), .wrFile(wrFile), .wrData(wrData), .alu(alu), .watchdogClearInstr(ev[0]),
		.sleepInstr(ev[1]), .watchdogTimeout(ev[2]), .pcStep(pcStep), .pcValue(pcValue), .flags(flags),
		.cfgView(cfgView), .pullupEnable(pullupEnable), .periImage());

	cpu_core_model i_cpu_core_model (.sys_clk(sys_clk), .rdEn(rdEn), .rdFile(rdFile), .wrEn(wrEn),
		.wrFile(wrFile), .wrData(wrData), .alu(alu), .ev(ev), .pcStep(pcStep));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nChecks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [6:0] f, input logic [7:0] e);
		expQ.push_back(e);
		i_cpu_core_model.issue(1'b1, f, 1'b0, 7'h00, 8'h00, ALU_NONE, 8'h00, 8'h00, 4'h0);
	endtask

	task automatic wr(input logic [6:0] f, input logic [7:0] d);
		i_cpu_core_model.issue(1'b0, 7'h00, 1'b1, f, d, ALU_NONE, 8'h00, 8'h00, 4'h0);
	endtask

	task automatic wrf(input logic [7:0] d);
		wr(FILE_FLAGS, d);
		fl = {d[7:5], fl[4:3], d[2:0]};
	endtask

	task automatic step(input logic [3:0] evs);
		i_cpu_core_model.issue(1'b0, 7'h00, 1'b0, 7'h00, 8'h00, ALU_NONE, 8'h00, 8'h00, evs);
	endtask

	task automatic do_reset(input logic por, input rstCause_t c);
		step(4'h0);
		@(posedge sys_clk);
		#1;
		sys_rst = 1'b1;
		resetPowerOn = por;
		resetCause = c;
		repeat (8) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
	endtask

	function automatic logic [2:0] aluFlags(aluOp_t o, logic [7:0] x, logic [7:0] y, logic [2:0] old);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] yy;
		yy = (o == ALU_SUB) ? ~y : y;
		s = {1'b0, x} + {1'b0, yy} + 9'(o == ALU_SUB);
		h = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + 5'(o == ALU_SUB);
		case (o)
			ALU_ADD, ALU_SUB: return {s[7:0] == 8'h00, h[4], s[8]};
			ALU_LOGIC: return {(x & y) == 8'h00, old[1:0]};
			ALU_ROT_LEFT: return {old[2:1], x[7]};
			ALU_ROT_RIGHT: return {old[2:1], x[0]};
			default: return old;
		endcase
	endfunction

	task automatic aluStep(input aluOp_t o, input logic [7:0] x, input logic [7:0] y);
		i_cpu_core_model.issue(1'b0, 7'h00, 1'b0, 7'h00, 8'h00, o, x, y, 4'h0);
		fl[2:0] = aluFlags(o, x, y, fl[2:0]);
		rd(FILE_FLAGS, fl);
	endtask

	task report_and_stop;
		$display("checks %0d errors %0d", nChecks, errors);
		if (errors == 0 && nChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// read result monitor
	// ****************************************
	always @(posedge sys_clk) begin
		if (rdPend) begin
			check(16'(rdData), 16'(expQ.pop_front()));
		end
		rdPend <= rdEn && !sys_rst;
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		sys_rst = 1'b1;
		resetPowerOn = 1'b1;
		resetCause = RST_MASTER_CLEAR_PIN;
		do_reset(1'b1, RST_MASTER_CLEAR_PIN);
		fl = 8'h18;
		check(16'(pcValue), 16'h0000);
		rd(FILE_FLAGS, 8'h18);
		wrf(8'h20);
		rd(7'h01, 8'hff);
		rd(7'h05, 8'h1f);
		rd(7'h0e, 8'h00);
		rd(7'h0f, 8'h00);
		rd(7'h40, 8'h00);
		wr(7'h70, 8'h5a);
		wrf(8'h00);
		rd(7'h70, 8'h5a);
		wr(7'h07, 8'h33);
		rd(7'h07, 8'h00);
		// port a keeps only its five implemented bits
		wr(7'h05, 8'hff);
		rd(7'h05, 8'h1f);
		check(16'(i_core_status_option_regs.periImage[15:8]), 16'h001f);
		$display("test bank map done");
		wr(7'h06, 8'ha5);
		wrf(8'h20);
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			v[2:0] = 3'(i);
			v[7] = i[0];
			wr(7'h01, v);
			step(4'h0);
			check(16'(cfgView), 16'({v[7:3], 4'(v[2:0]) + 4'h1, v[2:0]}));
			check(16'(pullupEnable), v[7] ? 16'h0000 : 16'h00a5);
			rd(7'h01, v);
		end
		$display("test config done");
		wrf(8'h00);
		wr(FILE_POINTER, 8'h25);
		wr(FILE_INDIRECT, 8'h3c);
		rd(7'h25, 8'h3c);
		wr(FILE_POINTER, 8'h00);
		rd(FILE_INDIRECT, 8'h00);
		$display("test indirect done");
		aluStep(ALU_ADD, 8'h0f, 8'h01);
		aluStep(ALU_ADD, 8'hff, 8'h01);
		aluStep(ALU_SUB, 8'h00, 8'h01);
		for (int i = 0; i < 15; i++) begin
			op = aluOp_t'(1 + i % 5);
			a = 8'($random(seed));
			b = 8'($random(seed));
			aluStep(op, a, b);
		end
		i_cpu_core_model.issue(1'b0, 7'h00, 1'b1, FILE_FLAGS, 8'h07, ALU_ADD, 8'h01, 8'h01, 4'h0);
		fl = {3'b000, fl[4:3], 3'b000};
		rd(FILE_FLAGS, fl);
		check(16'(flags), 16'(fl));
		$display("test alu done");
		wr(FILE_PC_HIGH, 8'hff);
		rd(FILE_PC_HIGH, 8'h1f);
		wr(FILE_PC_LOW, 8'h34);
		step(4'h8);
		check(16'(pcValue), 16'h1f34);
		step(4'h0);
		check(16'(pcValue), 16'h1f35);
		wr(FILE_POINTER, 8'h99);
		$display("test pc done");
		step(4'h2);
		fl[4:3] = 2'b10;
		rd(FILE_FLAGS, fl);
		wrf(8'h08);
		rd(FILE_FLAGS, fl);
		step(4'h4);
		fl[4] = 1'b0;
		rd(FILE_FLAGS, fl);
		step(4'h1);
		fl[4:3] = 2'b11;
		rd(FILE_FLAGS, fl);
		step(4'h6);
		fl[4:3] = 2'b00;
		rd(FILE_FLAGS, fl);
		step(4'h1);
		fl[4:3] = 2'b11;
		wrf(8'h20);
		do_reset(1'b0, RST_MASTER_CLEAR_PIN);
		check(16'(pcValue), 16'h0000);
		fl[7:5] = 3'b000;
		rd(FILE_FLAGS, fl);
		rd(FILE_POINTER, 8'h99);
		rd(FILE_PC_HIGH, 8'h00);
		do_reset(1'b0, RST_WATCHDOG);
		fl[4] = 1'b0;
		rd(FILE_FLAGS, fl);
		wrf(8'h20);
		rd(7'h01, 8'hff);
		// a brown-out reset must keep a set timeout flag, unlike the watchdog reset
		step(4'h1);
		fl[4:3] = 2'b11;
		do_reset(1'b0, RST_BROWNOUT);
		fl[7:5] = 3'b000;
		rd(FILE_FLAGS, fl);
		step(4'h0);
		step(4'h0);
		check(16'(expQ.size()), 16'h0000);
		$display("test events and resets done");
		report_and_stop;
	end
endmodule
